// File: logic/hpc_pkg.sv
package hpc_pkg;
  typedef enum logic [1:0]
  {
    HPC_MODE_ASYNC_A = 2'b00,
    HPC_MODE_BURST = 2'b01,
    HPC_MODE_ASYNC_B = 2'b10,
    HPC_MODE_SYNC = 2'b11
  } hpc_mode_t;

  typedef enum logic [1:0]
  {
    HPC_ST_IDLE = 2'b00,
    HPC_ST_WAIT = 2'b01,
    HPC_ST_ACK = 2'b10,
    HPC_ST_HOLD = 2'b11
  } hpc_state_t;

  localparam int HPC_DATA_W = 8;
  localparam int HPC_IRQ_W = 8;
  localparam logic [7:0] HPC_DATA_RST = 8'h00;
  localparam logic HPC_OE_RST_N = 1'b1;
  localparam int HPC_ACK_LAT = 2;
endpackage : hpc_pkg

// File: logic/hpc_sync2.sv
`timescale 1ns/1ps
module hpc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("hpc_sync2: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : hpc_sync2

// File: logic/hpc_host_port_control.sv
`timescale 1ns/1ps
module hpc_host_port_control
  import hpc_pkg::*;
#(
  parameter int ACK_LAT = hpc_pkg::HPC_ACK_LAT,
  parameter int IRQ_W = hpc_pkg::HPC_IRQ_W
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_data_bus_drive_en_n,
  input wire logic i_burst_final_xfer_n,
  input wire logic i_addr_sel_strap,
  input wire hpc_pkg::hpc_mode_t i_bus_mode,
  input wire logic i_cycle_req,
  input wire logic [hpc_pkg::HPC_DATA_W-1:0] i_rd_data,
  input wire logic [IRQ_W-1:0] i_irq_src,
  input wire logic i_primary_rx_line_pos,
  input wire logic i_primary_rx_line_neg,
  input wire logic i_backup_rx_line_pos,
  input wire logic i_backup_rx_line_neg,
  input wire logic i_use_backup,
  output logic [hpc_pkg::HPC_DATA_W-1:0] o_data_out,
  output logic [hpc_pkg::HPC_DATA_W-1:0] o_data_oe_n,
  output logic o_irq_out_n,
  output logic o_irq_oe_n,
  output logic o_cycle_done_ack,
  output logic o_burst_end,
  output logic o_port_ok,
  output logic o_rx_line_bit,
  output logic o_rx_line_valid
);
  import hpc_pkg::*;

  initial
  begin
    if (ACK_LAT < 1 || ACK_LAT > 15)
    begin
      $error("hpc_host_port_control: ACK_LAT must be 1..15");
    end
    if (IRQ_W < 1)
    begin
      $error("hpc_host_port_control: IRQ_W must be at least 1");
    end
  end

  logic drive_s;
  logic en_n_s;
  logic last_n_s;
  logic strap_s;
  logic req_s;
  logic pp_s;
  logic pn_s;
  logic bp_s;
  logic bn_s;
  logic [IRQ_W-1:0] irq_s;

  // Enable travels as a drive request so a flushed synchroniser means bus released
  hpc_sync2 #(.WIDTH(8 + IRQ_W)) u_sync (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_async({~i_data_bus_drive_en_n, i_burst_final_xfer_n, i_addr_sel_strap, i_cycle_req,
      i_primary_rx_line_pos, i_primary_rx_line_neg, i_backup_rx_line_pos,
      i_backup_rx_line_neg, i_irq_src}),
    .o_sync({drive_s, last_n_s, strap_s, req_s, pp_s, pn_s, bp_s, bn_s, irq_s})
  );
  assign en_n_s = ~drive_s;

  hpc_state_t state_q;
  logic [3:0] lat_q;
  logic burst_mode;
  assign burst_mode = (i_bus_mode == HPC_MODE_BURST);

  // Data bus pins: released on reset or while enable is high
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_data_out <= HPC_DATA_RST;
      o_data_oe_n <= {HPC_DATA_W{HPC_OE_RST_N}};
    end
    else
    begin
      o_data_out <= i_rd_data;
      o_data_oe_n <= {HPC_DATA_W{en_n_s}};
    end
  end

  // Open-drain interrupt: output stays low, only the enable moves
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_irq_out_n <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end
    else
    begin
      o_irq_out_n <= 1'b0;
      o_irq_oe_n <= ~(|irq_s);
    end
  end

  // Cycle handshake: acknowledge after latency, then hold until request drops
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      state_q <= HPC_ST_IDLE;
      lat_q <= 4'h0;
      o_cycle_done_ack <= 1'b0;
      o_burst_end <= 1'b0;
    end
    else
    begin
      case (state_q)
        HPC_ST_IDLE:
        begin
          o_cycle_done_ack <= 1'b0;
          o_burst_end <= 1'b0;
          if (req_s && strap_s)
          begin
            state_q <= HPC_ST_WAIT;
            lat_q <= 4'(ACK_LAT - 1);
          end
        end
        HPC_ST_WAIT:
        begin
          if (!req_s)
          begin
            state_q <= HPC_ST_IDLE;
          end
          else if (lat_q == 4'h0)
          begin
            state_q <= HPC_ST_ACK;
            o_cycle_done_ack <= 1'b1;
            o_burst_end <= burst_mode && !last_n_s;
          end
          else
          begin
            lat_q <= lat_q - 4'h1;
          end
        end
        HPC_ST_ACK:
        begin
          o_burst_end <= 1'b0;
          state_q <= HPC_ST_HOLD;
        end
        HPC_ST_HOLD:
        begin
          if (!req_s)
          begin
            o_cycle_done_ack <= 1'b0;
            state_q <= HPC_ST_IDLE;
          end
        end
        default:
        begin
          state_q <= HPC_ST_IDLE;
          o_cycle_done_ack <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_port_ok <= 1'b0;
    end
    else
    begin
      o_port_ok <= strap_s;
    end
  end

  // Differential line receive with protection select
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      o_rx_line_bit <= 1'b0;
      o_rx_line_valid <= 1'b0;
    end
    else if (i_use_backup)
    begin
      o_rx_line_bit <= bp_s;
      o_rx_line_valid <= bp_s ^ bn_s;
    end
    else
    begin
      o_rx_line_bit <= pp_s;
      o_rx_line_valid <= pp_s ^ pn_s;
    end
  end

  AST_BUS_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    en_n_s |=> (&o_data_oe_n))
    else $error("data bus driven while enable high");
  AST_BUS_DRIVE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !en_n_s |=> (o_data_oe_n == '0))
    else $error("data bus not driven while enabled");
  AST_IRQ_PULL: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (|irq_s) |=> (!o_irq_oe_n && !o_irq_out_n))
    else $error("interrupt not pulled low");
  AST_IRQ_FREE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !(|irq_s) |=> o_irq_oe_n)
    else $error("interrupt held without source");
  AST_RESET_TRI: assert property (@(posedge i_mclk)
    !i_resetn |=> (&o_data_oe_n && o_irq_oe_n && !o_cycle_done_ack))
    else $error("outputs not released in reset");
  AST_ACK_LATENCY: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(o_cycle_done_ack) |-> $past(req_s, 2) && $past(state_q) == HPC_ST_WAIT)
    else $error("acknowledge without request");
  AST_ACK_HOLD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (o_cycle_done_ack && req_s) |=> o_cycle_done_ack)
    else $error("acknowledge dropped early");
  AST_STRAP_GATE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state_q == HPC_ST_IDLE && !strap_s) |=> state_q == HPC_ST_IDLE)
    else $error("cycle started with strap low");
  AST_BURST_IGNORE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_burst_end |-> $past(burst_mode) && !$past(last_n_s))
    else $error("burst end outside burst mode");
  AST_RX_SELECT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_use_backup |=> o_rx_line_bit == $past(bp_s))
    else $error("backup port not selected");

  COV_CYCLE: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    $rose(o_cycle_done_ack));
  COV_BURST_END: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_burst_end);
  COV_IRQ: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(o_irq_oe_n));
  COV_BACKUP: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    i_use_backup && o_rx_line_valid);
endmodule : hpc_host_port_control

// File: verification/hpc_host_bfm.sv
`timescale 1ns/1ps
module hpc_host_bfm (
  input wire logic i_mclk,
  input wire logic i_start,
  input wire logic i_last,
  input wire logic i_burst,
  input wire logic i_ack,
  output logic o_req,
  output logic o_final_n,
  output logic o_done
);
  initial
  begin
    o_req = 1'h0;
    o_done = 1'h0;
  end
  assign o_final_n = i_burst ? !(o_req && i_last) : 1'h0;
  always @(posedge i_mclk)
  begin
    if (i_start && !o_req && !o_done && !i_ack)
      o_req <= 1'h1;
    else if (o_req && i_ack)
    begin
      o_req <= 1'h0;
      o_done <= 1'h1;
    end
    else if (!i_start)
      o_done <= 1'h0;
  end
endmodule : hpc_host_bfm

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hpc_pkg::*;
  logic mclk = 0, rst_n = 0, en_n = 1, strap = 1, bk = 0, go = 0, last = 0;
  logic pp = 0, pn = 1, bp = 0, bn = 0, ioutn, ioen, ack, bend, pok, rxb, rxv;
  logic req, fin_n, done;
  logic [7:0] rd = 8'hA5, irq = 8'h00, dout, doen;
  hpc_mode_t mode = HPC_MODE_BURST;
  int num_errors = 0, checks_done = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  hpc_host_port_control #(.ACK_LAT(HPC_ACK_LAT), .IRQ_W(8)) i_hpc_host_port_control (
    .i_mclk(mclk),
    .i_resetn(rst_n), .i_data_bus_drive_en_n(en_n), .i_burst_final_xfer_n(fin_n),
    .i_addr_sel_strap(strap), .i_bus_mode(mode), .i_cycle_req(req), .i_rd_data(rd),
    .i_irq_src(irq), .i_primary_rx_line_pos(pp), .i_primary_rx_line_neg(pn),
    .i_backup_rx_line_pos(bp), .i_backup_rx_line_neg(bn), .i_use_backup(bk),
    .o_data_out(dout), .o_data_oe_n(doen), .o_irq_out_n(ioutn), .o_irq_oe_n(ioen),
    .o_cycle_done_ack(ack), .o_burst_end(bend), .o_port_ok(pok), .o_rx_line_bit(rxb),
    .o_rx_line_valid(rxv));
  hpc_host_bfm i_hpc_host_bfm (.i_mclk(mclk), .i_start(go), .i_last(last),
    .i_burst(mode == HPC_MODE_BURST), .i_ack(ack), .o_req(req), .o_final_n(fin_n),
    .o_done(done));
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task t_bus;
    en_n = 0;
    step(2);
    chk(doen, 8'hFF);
    step(1);
    chk(doen, 8'h00);
    rd = 8'h3C;
    step(1);
    chk(dout, 8'h3C);
    en_n = 1;
    step(3);
    chk(doen, 8'hFF);
    $display("t_bus done");
  endtask : t_bus
  task t_irq;
    for (int i = 0; i < 8; i++)
    begin
      irq = 8'h01 << i;
      step(3);
      chk({6'h00, ioen, ioutn}, 8'h00);
      irq = 8'h00;
      step(3);
      chk({7'h00, ioen}, 8'h01);
    end
    $display("t_irq done");
  endtask : t_irq
  task t_cyc(input hpc_mode_t m, input logic l);
    int n;
    mode = m;
    last = l;
    go = 1;
    n = 0;
    while (!ack && n < 40)
    begin
      step(1);
      n++;
    end
    // One edge to raise the request, then ACK_LAT + 3 edges from pin to acknowledge
    chk(8'(n), 8'(HPC_ACK_LAT + 4));
    chk({7'h00, bend}, {7'h00, m == HPC_MODE_BURST && l});
    go = 0;
    step(1);
    chk({6'h00, done, req}, 8'h02);
    step(7);
    chk({7'h00, ack}, 8'h00);
    $display("t_cyc done");
  endtask : t_cyc
  task t_strap;
    strap = 0;
    go = 1;
    step(20);
    chk({6'h00, ack, pok}, 8'h00);
    strap = 1;
    step(8);
    chk({6'h00, ack, pok}, 8'h03);
    go = 0;
    step(8);
    $display("t_strap done");
  endtask : t_strap
  task t_rx;
    for (int k = 0; k < 4; k++)
    begin
      bk = k[0];
      pp = k[1];
      pn = ~k[1];
      bp = ~k[1];
      bn = ~k[1];
      step(3);
      chk({6'h00, rxb, rxv}, bk ? {6'h00, ~k[1], 1'h0} : {6'h00, k[1], 1'h1});
    end
    $display("t_rx done");
  endtask : t_rx
  task t_rst;
    en_n = 0;
    irq = 8'h81;
    step(4);
    rst_n = 0;
    step(1);
    chk(doen, 8'hFF);
    chk({6'h00, ioen, ack}, 8'h02);
    rst_n = 1;
    en_n = 1;
    irq = 8'h00;
    step(1);
    chk(doen, 8'hFF);
    step(2);
    $display("t_rst done");
  endtask : t_rst
  initial
  begin
    step(2);
    chk(doen, 8'hFF);
    rst_n = 1;
    step(2);
    t_bus();
    t_irq();
    t_cyc(HPC_MODE_BURST, 1);
    t_cyc(HPC_MODE_BURST, 0);
    t_cyc(HPC_MODE_ASYNC_A, 1);
    t_cyc(HPC_MODE_ASYNC_B, 1);
    t_cyc(HPC_MODE_SYNC, 1);
    t_strap();
    t_rx();
    t_rst();
    complete_run();
  end
endmodule : tb_top
